/* File: dv/pcg_board.sv */
// Board model: pull-ups and external drivers on the port C pins
`timescale 1ns/1ns
module pcg_board (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	// Pull-ups, so a released pin never keeps its last driven value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule

/* File: dv/tb_port_c_gpio_with_pin_remap.sv */
// Self-checking bench for the port C pin block
`timescale 1ns/1ns
module tb_port_c_gpio_with_pin_remap;
	logic                mclk;
	logic                rst_b;
	pcg_pkg::pcg_bus_t   bus;
	pcg_pkg::pcg_fuse_t  fuse;
	pcg_pkg::pcg_ovr_t   asu;
	pcg_pkg::pcg_ovr_t   ssu;
	pcg_pkg::pcg_drive_t sd;
	pcg_pkg::pcg_drive_t pd;
	pcg_pkg::pcg_drive_t cd;
	logic [5:0]          per;
	logic [7:0]          rdata;
	logic [7:0]          pin_in;
	logic [7:0]          pin_out;
	logic [7:0]          pin_oe;
	logic [7:0]          ain;
	logic [7:0]          din;
	logic [7:0]          ext_en;
	logic [7:0]          ext_val;
	logic                t3in;
	logic                c2in;
	logic [7:0]          lat;
	logic [7:0]          dir;
	logic [7:0]          ana;
	logic [7:0]          e;
	int                  bad_count;
	int                  checks_done;
	int                  cyc;

	pcg_port_c DUT (
		.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .fuse(fuse),
		.async_sync_serial_unit(asu), .sync_serial_port_unit(ssu),
		.serial_drive(sd), .ssp_drive(pd), .ccp_drive(cd),
		.capture_compare_unit2(per[5]), .capture_compare2_oe(per[4]),
		.capture_compare_unit3(per[3]), .capture_compare3_oe(per[2]),
		.pwm2_output_b(per[1]), .pwm2b_oe(per[0]),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.analog_in_en(ain), .digital_in(din),
		.timer3_clock_input(t3in), .capture_compare2_in(c2in)
	);

	pcg_board board (
		.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard, far above the under one thousand cycles the run needs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// Effective direction: async unit beats sync unit beats stored bits
	function automatic logic [7:0] edir(input logic [7:0] d);
		return (d & ~asu.force_en & ~ssu.force_en) | (asu.force_en & asu.force_dir)
			| (ssu.force_en & ~asu.force_en & ssu.force_dir);
	endfunction

	// Pin level seen on the board for a given effective direction
	function automatic logic [7:0] lvl(input logic [7:0] ed);
		return (lat & ~ed) | (ed & ~ext_en) | (ed & ext_en & ext_val);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		bus = '0;
		fuse = 5'b11110;
		asu = '0;
		ssu = '0;
		sd = '0;
		pd = '0;
		cd = '0;
		per = '0;
		ext_en = 8'h00;
		ext_val = 8'h00;
		rst_b = 1'b0;
		bad_count = 0;
		checks_done = 0;
		cyc = 0;
		void'($urandom(68));
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk(pin_oe, 8'h00);
		chk(ain, 8'hFC);
		chk(din, 8'h03);
		rd(pcg_pkg::OFS_DIRECTION, 8'hFF);
		rd(pcg_pkg::OFS_ANALOG_SELECT, 8'hFC);
		rd(4'h9, 8'h00);
		for (int n = 0; n < 40; n++) begin
			lat = 8'($urandom);
			dir = 8'($urandom);
			ana = 8'($urandom);
			@(posedge mclk);
			asu <= 16'($urandom);
			ssu <= 16'($urandom);
			ext_en <= 8'($urandom);
			ext_val <= 8'($urandom);
			wr((n % 2) ? pcg_pkg::OFS_LATCH : pcg_pkg::OFS_PIN_DATA, lat);
			wr(pcg_pkg::OFS_DIRECTION, dir);
			wr(pcg_pkg::OFS_ANALOG_SELECT, ana);
			repeat (3) @(posedge mclk);
			#1;
			e = edir(dir);
			chk(pin_oe, ~e);
			chk(pin_out & ~e, lat & ~e);
			chk(ain, ana & pcg_pkg::ANALOG_IMPL);
			chk(din, lvl(e) & ~(ana & pcg_pkg::ANALOG_IMPL));
			rd(pcg_pkg::OFS_DIRECTION, dir);
			rd(pcg_pkg::OFS_LATCH, lat);
			rd(pcg_pkg::OFS_ANALOG_SELECT, ana & pcg_pkg::ANALOG_IMPL);
			rd(pcg_pkg::OFS_PIN_DATA, lvl(e) & ~(ana & pcg_pkg::ANALOG_IMPL));
		end
		// Data write then latch read with no gap between the strobes
		@(posedge mclk);
		bus.addr <= pcg_pkg::OFS_PIN_DATA;
		bus.wdata <= 8'h5A;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
		bus.addr <= pcg_pkg::OFS_LATCH;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, 8'h5A);
		// Shared pins in analog mode, three drivers overlapping on bit 5
		asu <= '0;
		ssu <= '0;
		lat = 8'h00;
		wr(pcg_pkg::OFS_DIRECTION, 8'h00);
		wr(pcg_pkg::OFS_LATCH, 8'h00);
		wr(pcg_pkg::OFS_ANALOG_SELECT, 8'hFF);
		sd <= {8'hA1, 8'h01};
		pd <= {8'hA3, 8'hA2};
		cd <= {8'hE7, 8'hFF};
		repeat (3) @(posedge mclk);
		#1;
		chk(pin_out, 8'h47);
		sd <= '0;
		pd <= '0;
		cd <= '0;
		fuse <= 5'b11000;
		per <= 6'h3F;
		repeat (3) @(posedge mclk);
		#1;
		chk(pin_out, 8'h43);
		rd(pcg_pkg::OFS_FUSE_STATUS, 8'h03);
		// Variant with unit 3 elsewhere keeps bit 6 on the latch
		fuse <= 5'b11001;
		repeat (3) @(posedge mclk);
		#1;
		chk(pin_out, 8'h03);
		fuse <= 5'b00110;
		repeat (3) @(posedge mclk);
		#1;
		chk(pin_out, 8'h00);
		rd(pcg_pkg::OFS_FUSE_STATUS, 8'h0C);
		// Relocatable inputs on bits 1 and 0
		per <= '0;
		ext_en <= 8'h03;
		wr(pcg_pkg::OFS_DIRECTION, 8'h03);
		for (int k = 0; k < 3; k++) begin
			fuse <= (k < 2) ? 5'b11110 : 5'b00110;
			ext_val <= (k == 0) ? 8'h01 : ((k == 1) ? 8'h02 : 8'h03);
			repeat (4) @(posedge mclk);
			#1;
			chk({6'h00, t3in, c2in}, (k == 0) ? 8'h02 : ((k == 1) ? 8'h01 : 8'h00));
		end
		conclude();
	end
endmodule

/* File: hw/pcg_pkg.sv */
// Package: port C register map, fields, reset values and carriers
package pcg_pkg;
	localparam int unsigned WIDTH = 8;
	localparam int unsigned AW    = 4;

	// Register indices on the plain register port
	localparam logic [AW-1:0] OFS_PIN_DATA      = 4'h0;
	localparam logic [AW-1:0] OFS_LATCH         = 4'h1;
	localparam logic [AW-1:0] OFS_DIRECTION     = 4'h2;
	localparam logic [AW-1:0] OFS_ANALOG_SELECT = 4'h3;
	localparam logic [AW-1:0] OFS_FUSE_STATUS   = 4'h4;

	// Reset values: all inputs, analog selected where a select bit exists
	localparam logic [WIDTH-1:0] RST_DIRECTION = 8'hFF;
	localparam logic [WIDTH-1:0] RST_LATCH     = 8'h00;
	localparam logic [WIDTH-1:0] RST_ANALOG    = 8'hFC;
	// Bits that own an analog select bit (bits 1 and 0 have none)
	localparam logic [WIDTH-1:0] ANALOG_IMPL   = 8'hFC;

	// Pin positions of relocatable functions
	localparam int unsigned BIT_TIMER3_CLK = 0;
	localparam int unsigned BIT_CC2        = 1;
	localparam int unsigned BIT_PWM2B      = 0;
	localparam int unsigned BIT_CC3        = 6;

	// Fuse status read-back field positions
	localparam int unsigned FS_T3    = 0;
	localparam int unsigned FS_C2    = 1;
	localparam int unsigned FS_PWM2B = 2;
	localparam int unsigned FS_C3    = 3;

	// Peripheral drive request for one pin group
	typedef struct packed {
		logic [WIDTH-1:0] en;
		logic [WIDTH-1:0] val;
	} pcg_drive_t;

	// Serial unit direction override: force mask and forced direction
	typedef struct packed {
		logic [WIDTH-1:0] force_en;
		logic [WIDTH-1:0] force_dir;
	} pcg_ovr_t;

	// Configuration fuses, zero = relocated
	typedef struct packed {
		logic timer3_clock_relocate_fuse;
		logic capture_compare2_relocate_fuse;
		logic pwm2b_relocate_fuse;
		logic capture_compare3_relocate_fuse;
		logic variant_cc3_on_port_e;
	} pcg_fuse_t;

	// Register port
	typedef struct packed {
		logic [AW-1:0]    addr;
		logic [WIDTH-1:0] wdata;
		logic             wr;
		logic             rd;
	} pcg_bus_t;
endpackage

/* File: hw/pcg_port_c.sv */
// Port C general-purpose I/O with fuse pin relocation
//
// Overview of operation
// - Eight pins, each independently an input or an output.
// - Direction bit one turns the pin driver off; pin is input.
// - Direction bit zero drives the latch bit onto the pin.
// - Latch has its own address; read-modify-write sees latch values.
// - Timer3 clock input on bit 0 unless its fuse is zero.
// - Capture-compare 2 on bit 1 unless its fuse is zero.
// - Cleared fuses bring PWM2 B to bit 0, unit 3 to bit 6. Unit 3 stays off port C while variant_cc3_on_port_e is set.
// - Serial units may force a pin's direction either way.
// - After reset every pin is an input, analog on bits 7 to 2.
// - Direction reads return stored bits despite any override.
// - Highest fixed priority peripheral wins a shared pin.
// - Analog inputs are active only when analog select is set.
// - Digital peripheral outputs still drive pins in analog mode.
// - Bits 1 and 0 have no analog select; always digital.
// - Data writes go to latch; data reads return pin levels.
// - Analog select one disables the digital input buffer.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module pcg_port_c (
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire pcg_pkg::pcg_bus_t           bus,
	output logic [pcg_pkg::WIDTH-1:0]        rdata,
	input  wire pcg_pkg::pcg_fuse_t          fuse,
	input  wire pcg_pkg::pcg_ovr_t           async_sync_serial_unit,
	input  wire pcg_pkg::pcg_ovr_t           sync_serial_port_unit,
	input  wire pcg_pkg::pcg_drive_t         serial_drive,
	input  wire pcg_pkg::pcg_drive_t         ssp_drive,
	input  wire pcg_pkg::pcg_drive_t         ccp_drive,
	input  wire logic                        capture_compare_unit2,
	input  wire logic                        capture_compare2_oe,
	input  wire logic                        capture_compare_unit3,
	input  wire logic                        capture_compare3_oe,
	input  wire logic                        pwm2_output_b,
	input  wire logic                        pwm2b_oe,
	input  wire logic [pcg_pkg::WIDTH-1:0]   pin_in,
	output logic [pcg_pkg::WIDTH-1:0]        pin_out,
	output logic [pcg_pkg::WIDTH-1:0]        pin_oe,
	output logic [pcg_pkg::WIDTH-1:0]        analog_in_en,
	output logic [pcg_pkg::WIDTH-1:0]        digital_in,
	output logic                             timer3_clock_input,
	output logic                             capture_compare2_in
);
	localparam int unsigned NSRC = 4;

	logic [pcg_pkg::WIDTH-1:0] port_c_latch;
	logic [pcg_pkg::WIDTH-1:0] port_c_direction;
	logic [pcg_pkg::WIDTH-1:0] port_c_analog_select;
	pcg_pkg::pcg_drive_t       reloc_drive;
	pcg_pkg::pcg_drive_t       src [NSRC];
	pcg_pkg::pcg_drive_t       periph;
	logic [pcg_pkg::WIDTH-1:0] eff_dir;
	logic [pcg_pkg::WIDTH-1:0] dig_in;
	logic [pcg_pkg::WIDTH-1:0] next_pin_out;
	logic [pcg_pkg::WIDTH-1:0] next_pin_oe;
	logic [pcg_pkg::WIDTH-1:0] next_rdata;

	////////////////////////////////////////////////////////////////////////
	// Registers

	pcg_regs u_regs (
		.mclk                 (mclk),
		.rst_b                (rst_b),
		.bus                  (bus),
		.port_c_latch         (port_c_latch),
		.port_c_direction     (port_c_direction),
		.port_c_analog_select (port_c_analog_select)
	);

	////////////////////////////////////////////////////////////////////////
	// Relocated functions and priority

	// Functions land here only when their fuse is cleared, or by default
	always_comb begin
		reloc_drive = '0;
		if (fuse.capture_compare2_relocate_fuse) begin
			reloc_drive.en[pcg_pkg::BIT_CC2]  = capture_compare2_oe;
			reloc_drive.val[pcg_pkg::BIT_CC2] = capture_compare_unit2;
		end
		if (!fuse.pwm2b_relocate_fuse) begin
			reloc_drive.en[pcg_pkg::BIT_PWM2B]  = pwm2b_oe;
			reloc_drive.val[pcg_pkg::BIT_PWM2B] = pwm2_output_b;
		end
		// Variant with unit 3 on port E leaves port C untouched
		if (!fuse.capture_compare3_relocate_fuse && !fuse.variant_cc3_on_port_e) begin
			reloc_drive.en[pcg_pkg::BIT_CC3]  = capture_compare3_oe;
			reloc_drive.val[pcg_pkg::BIT_CC3] = capture_compare_unit3;
		end
	end

	assign src[0] = serial_drive;
	assign src[1] = ssp_drive;
	assign src[2] = ccp_drive;
	assign src[3] = reloc_drive;

	pcg_prio_mux #(.NSRC(NSRC)) u_prio (
		.src (src),
		.sel (periph)
	);

	////////////////////////////////////////////////////////////////////////
	// Direction override and pin drive

	// Override changes the effective direction only, never the register
	always_comb begin
		eff_dir = port_c_direction;
		for (int i = 0; i < pcg_pkg::WIDTH; i++) begin
			if (sync_serial_port_unit.force_en[i]) begin
				eff_dir[i] = sync_serial_port_unit.force_dir[i];
			end
			if (async_sync_serial_unit.force_en[i]) begin
				eff_dir[i] = async_sync_serial_unit.force_dir[i];
			end
		end
	end

	// Analog select does not gate outputs
	always_comb begin
		for (int i = 0; i < pcg_pkg::WIDTH; i++) begin
			next_pin_oe[i]  = !eff_dir[i];
			next_pin_out[i] = periph.en[i] ? periph.val[i] : port_c_latch[i];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_oe  <= '0;
			pin_out <= '0;
		end else begin
			pin_oe  <= next_pin_oe;
			pin_out <= next_pin_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input path

	assign dig_in = pin_in & ~port_c_analog_select;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			analog_in_en        <= pcg_pkg::RST_ANALOG;
			digital_in          <= '0;
			timer3_clock_input  <= 1'b0;
			capture_compare2_in <= 1'b0;
		end else begin
			analog_in_en <= port_c_analog_select;
			digital_in   <= dig_in;
			// Relocated away: this port no longer feeds the function
			timer3_clock_input  <= fuse.timer3_clock_relocate_fuse &
				dig_in[pcg_pkg::BIT_TIMER3_CLK];
			capture_compare2_in <= fuse.capture_compare2_relocate_fuse &
				dig_in[pcg_pkg::BIT_CC2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read-back, one cycle later

	always_comb begin
		next_rdata = '0;
		case (bus.addr)
			pcg_pkg::OFS_PIN_DATA:      next_rdata = dig_in;
			pcg_pkg::OFS_LATCH:         next_rdata = port_c_latch;
			pcg_pkg::OFS_DIRECTION:     next_rdata = port_c_direction;
			pcg_pkg::OFS_ANALOG_SELECT: next_rdata = port_c_analog_select;
			pcg_pkg::OFS_FUSE_STATUS: begin
				next_rdata[pcg_pkg::FS_T3]  = fuse.timer3_clock_relocate_fuse;
				next_rdata[pcg_pkg::FS_C2]  = fuse.capture_compare2_relocate_fuse;
				next_rdata[pcg_pkg::FS_PWM2B] = fuse.pwm2b_relocate_fuse;
				next_rdata[pcg_pkg::FS_C3]  = fuse.capture_compare3_relocate_fuse;
			end
			default:                    next_rdata = '0;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= '0;
		end else begin
			rdata <= bus.rd ? next_rdata : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_dir_input_off: assert property (@(posedge mclk) disable iff (!rst_b)
		(port_c_direction == 8'hFF && !(|async_sync_serial_unit.force_en) &&
		!(|sync_serial_port_unit.force_en)) |=> pin_oe == 8'h00)
		else $error("input pin driven");

	a_dir_output_latch: assert property (@(posedge mclk) disable iff (!rst_b)
		(!(|periph.en) && !eff_dir[3]) |=> (pin_oe[3] && pin_out[3] == $past(port_c_latch[3])))
		else $error("latch not on output pin");

	a_latch_write: assert property (@(posedge mclk) disable iff (!rst_b)
		(bus.wr && bus.addr == pcg_pkg::OFS_LATCH) |=> port_c_latch == $past(bus.wdata))
		else $error("latch write lost");

	a_data_write_latch: assert property (@(posedge mclk) disable iff (!rst_b)
		(bus.wr && bus.addr == pcg_pkg::OFS_PIN_DATA) ##1 (bus.rd && bus.addr == pcg_pkg::OFS_LATCH)
		|=> rdata == $past(bus.wdata, 2))
		else $error("data write not in latch");

	a_t3_relocate: assert property (@(posedge mclk) disable iff (!rst_b)
		!fuse.timer3_clock_relocate_fuse |=> !timer3_clock_input)
		else $error("timer3 input not relocated");

	a_cc2_drive: assert property (@(posedge mclk) disable iff (!rst_b)
		(fuse.capture_compare2_relocate_fuse && capture_compare2_oe && !(|serial_drive.en[1]) &&
		!ssp_drive.en[1] && !ccp_drive.en[1]) |=> pin_out[1] == $past(capture_compare_unit2))
		else $error("unit 2 not on bit 1");

	a_pwm2b_relocate: assert property (@(posedge mclk) disable iff (!rst_b)
		(fuse.pwm2b_relocate_fuse && fuse.timer3_clock_relocate_fuse && !(|src[0].en[0]) &&
		!src[1].en[0] && !src[2].en[0]) |=> pin_out[0] == $past(port_c_latch[0]))
		else $error("pwm2b on pin while fuse set");

	a_override_dir: assert property (@(posedge mclk) disable iff (!rst_b)
		async_sync_serial_unit.force_en[7] |=> pin_oe[7] == !$past(async_sync_serial_unit.force_dir[7]))
		else $error("serial override ignored");

	a_dir_readback: assert property (@(posedge mclk) disable iff (!rst_b)
		(bus.rd && bus.addr == pcg_pkg::OFS_DIRECTION) |=> rdata == $past(port_c_direction))
		else $error("direction read altered");

	a_priority_win: assert property (@(posedge mclk) disable iff (!rst_b)
		(serial_drive.en[5] && ssp_drive.en[5]) |=> pin_out[5] == $past(serial_drive.val[5]))
		else $error("priority order wrong");

	a_analog_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		port_c_analog_select[4] |=> (!digital_in[4] && analog_in_en[4]))
		else $error("analog pin reads digital");

	a_low_bits_digital: assert property (@(posedge mclk) disable iff (!rst_b)
		port_c_analog_select[1:0] == 2'h0)
		else $error("bits 1..0 analog");
endmodule

/* File: hw/pcg_prio_mux.sv */
// Fixed-priority selection of peripheral drivers for one port
`timescale 1ns/1ns
module pcg_prio_mux #(
	parameter int unsigned NSRC = 4
) (
	input  wire pcg_pkg::pcg_drive_t src [NSRC],
	output pcg_pkg::pcg_drive_t      sel
);
	// Index 0 has the highest priority
	always_comb begin
		sel = '0;
		for (int p = 0; p < pcg_pkg::WIDTH; p++) begin
			for (int s = NSRC - 1; s >= 0; s--) begin
				if (src[s].en[p]) begin
					sel.en[p]  = 1'b1;
					sel.val[p] = src[s].val[p];
				end
			end
		end
	end
endmodule

/* File: hw/pcg_regs.sv */
// Port configuration registers: latch, direction, analog select
`timescale 1ns/1ns
module pcg_regs (
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	input  wire pcg_pkg::pcg_bus_t          bus,
	output logic [pcg_pkg::WIDTH-1:0]       port_c_latch,
	output logic [pcg_pkg::WIDTH-1:0]       port_c_direction,
	output logic [pcg_pkg::WIDTH-1:0]       port_c_analog_select
);
	// Writes to pin data and latch both land in the latch
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			port_c_latch <= pcg_pkg::RST_LATCH;
		end else if (bus.wr && (bus.addr == pcg_pkg::OFS_PIN_DATA ||
				bus.addr == pcg_pkg::OFS_LATCH)) begin
			port_c_latch <= bus.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			port_c_direction <= pcg_pkg::RST_DIRECTION;
		end else if (bus.wr && bus.addr == pcg_pkg::OFS_DIRECTION) begin
			port_c_direction <= bus.wdata;
		end
	end

	// Unimplemented select bits stay zero
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			port_c_analog_select <= pcg_pkg::RST_ANALOG;
		end else if (bus.wr && bus.addr == pcg_pkg::OFS_ANALOG_SELECT) begin
			port_c_analog_select <= bus.wdata & pcg_pkg::ANALOG_IMPL;
		end
	end
endmodule
